// ===== rtl/srl_pkg.sv
// constants shared by the shift/storage latch block
package srl_pkg;
	localparam int unsigned WIDTH      = 8;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [7:0]  SHIFT_RST  = 8'h00;
	localparam logic [7:0]  STORE_RST  = 8'h00;
	localparam int unsigned FIRST_BIT  = 0;
	localparam int unsigned LAST_BIT   = 7;
endpackage : srl_pkg

// ===== rtl/srl_pin_sync.sv
// three-stage pin synchroniser with agreement-based change detection
`timescale 1ns/1ps
module srl_pin_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin and clean level
	input  wire logic pin,
	output logic      level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	// first stage feeds only the second; level moves when stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_q <= s3_q;
		end
	end

	assign level = level_q;
endmodule : srl_pin_sync

// ===== rtl/srl_latch.sv
// serial-in shift register feeding a storage register with tri-state outputs
`timescale 1ns/1ps
// How it works
// - eight-stage shift register shifts only on shift clock rising edge
// - on rise with clear high, stage 0 takes serial in, others shift up
// - shift clock falling edge leaves shift stages unchanged
// - clear low forces every shift stage to zero, overriding everything
// - storage clock rising edge copies all eight shift stages to storage
// - storage holds value except on storage clock rising edge
// - output enable low drives outputs from storage, high releases them
// - shift and storage clocks are independent; shifting leaves the parallel outputs steady, only cascade moves
module srl_latch
	import srl_pkg::*;
#(
	parameter int unsigned W = WIDTH
)
(
	// system
	input  wire logic         clk,
	input  wire logic         rstn,
	// host pins
	input  wire logic         serial_in,
	input  wire logic         shift_clock,
	input  wire logic         shift_clear_n,
	input  wire logic         storage_clock,
	input  wire logic         output_enable_n,
	// parallel outputs, split into value and enable
	output logic [W-1:0]      parallel_out,
	output logic [W-1:0]      parallel_oe,
	output logic              parallel_out_first,
	output logic              parallel_out_last,
	// cascade
	output logic              cascade_serial_out
);
	////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_a_q;
	logic rst_b_q;
	logic rst_n;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_a_q <= 1'b0;
			rst_b_q <= 1'b0;
		end
		else
		begin
			rst_a_q <= 1'b1;
			rst_b_q <= rst_a_q;
		end
	end
	assign rst_n = rst_b_q;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic si_s;
	logic sck_s;
	logic clr_n_s;
	logic stg_s;
	logic oe_s;
	logic oe_pin;

	// enable made active high ahead of its synchroniser, so the reset level of zero keeps outputs released
	assign oe_pin = ~output_enable_n;

	// all five paths have the same depth, so serial data keeps its place against the shift clock
	// clear reads as active for a few cycles after reset; harmless, the stages are zero then anyway
	srl_pin_sync u_si  (.clk(clk), .rst_n(rst_n), .pin(serial_in),     .level(si_s));
	srl_pin_sync u_sck (.clk(clk), .rst_n(rst_n), .pin(shift_clock),   .level(sck_s));
	srl_pin_sync u_clr (.clk(clk), .rst_n(rst_n), .pin(shift_clear_n), .level(clr_n_s));
	srl_pin_sync u_stg (.clk(clk), .rst_n(rst_n), .pin(storage_clock), .level(stg_s));
	srl_pin_sync u_oe  (.clk(clk), .rst_n(rst_n), .pin(oe_pin),        .level(oe_s));

	////////////////////////////////////////////////////////////////////////
	// edge detection on the clean clock levels
	// pin edge to register change is five clk edges: three sync flops, agreement, register
	logic sck_prev_q;
	logic stg_prev_q;
	logic sck_rise;
	logic stg_rise;

	// prev starts at the synchroniser's reset level, matching the idle-low clock pins
	// limitation: a clock pin held high through reset shows one rise once it has been seen
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_prev_q <= 1'b0;
			stg_prev_q <= 1'b0;
		end
		else
		begin
			sck_prev_q <= sck_s;
			stg_prev_q <= stg_s;
		end
	end

	// falling edges are never decoded, which is what leaves them without effect
	assign sck_rise = sck_s & ~sck_prev_q;
	assign stg_rise = stg_s & ~stg_prev_q;

	// one pin edge must move the registers exactly once
	a_sck_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		sck_rise |=> !sck_rise)
		else $error("shift edge pulse too long");
	a_stg_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		stg_rise |=> !stg_rise)
		else $error("storage edge pulse too long");

	////////////////////////////////////////////////////////////////////////
	// shift register
	logic [W-1:0] shift_q;
	logic [W-1:0] shift_d;
	logic [W-1:0] shift_next;

	// stage 0 takes the serial bit, so the first bit in ends at the last stage after eight rises
	assign shift_next = {shift_q[W-2:0], si_s};
	// clear dominates; falling edges fall through to hold
	assign shift_d = !clr_n_s ? SHIFT_RST[W-1:0]
		: sck_rise ? shift_next
		: shift_q;

	// only the released internal reset is asynchronous; clear is a sampled pin
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= SHIFT_RST[W-1:0];
		else
			shift_q <= shift_d;
	end

	// clear, with or without a shift edge, empties every stage
	a_clear_zeroes: assert property (@(posedge clk) disable iff (!rst_n)
		!clr_n_s |=> shift_q == '0)
		else $error("shift not cleared");
	a_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
		!clr_n_s && sck_rise |=> shift_q == '0)
		else $error("shift edge beat clear");
	// a rise with clear high moves every stage by one; clear high without a rise holds
	a_shift_moves: assert property (@(posedge clk) disable iff (!rst_n)
		clr_n_s && sck_rise |=> shift_q == {$past(shift_q[W-2:0]), $past(si_s)})
		else $error("shift wrong");
	a_shift_holds: assert property (@(posedge clk) disable iff (!rst_n)
		clr_n_s && !sck_rise |=> $stable(shift_q))
		else $error("shift moved without edge");

	////////////////////////////////////////////////////////////////////////
	// storage register; clear does not touch it
	logic [W-1:0] store_q;
	logic [W-1:0] store_d;

	// shift_q sampled before this edge's shift, as with independent clocks
	assign store_d = stg_rise ? shift_q : store_q;

	// storage keeps its own reset; the clear pin never reaches it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			store_q <= STORE_RST[W-1:0];
		else
			store_q <= store_d;
	end

	// a rise copies the pre-edge shift value; nothing else, clear included, moves it
	// the two ends are checked apart as they also leave on their own ports
	a_store_loads: assert property (@(posedge clk) disable iff (!rst_n)
		stg_rise |=> store_q == $past(shift_q))
		else $error("store not loaded");
	a_out_ends: assert property (@(posedge clk) disable iff (!rst_n)
		stg_rise |=> parallel_out_first == $past(shift_q[FIRST_BIT]) && parallel_out_last == $past(shift_q[W-1]))
		else $error("end outputs not loaded");
	a_store_holds: assert property (@(posedge clk) disable iff (!rst_n)
		!stg_rise |=> $stable(store_q))
		else $error("store changed");
	a_store_indep: assert property (@(posedge clk) disable iff (!rst_n)
		sck_rise && !stg_rise |=> $stable(parallel_out))
		else $error("outputs moved on shift");
	a_clear_spares_store: assert property (@(posedge clk) disable iff (!rst_n)
		!clr_n_s && !stg_rise |=> $stable(store_q))
		else $error("clear reached storage");

	////////////////////////////////////////////////////////////////////////
	// outputs
	logic oe_q;

	// enable registered once more so value and enable both leave from flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			oe_q <= 1'b0;
		else
			oe_q <= oe_s;
	end

	// value and enable are separate ports; the pad ring or bench forms the three-state pin
	// limitation: a disable reaches the pins five clk edges after the pin changes
	assign parallel_out       = store_q;
	assign parallel_oe        = {W{oe_q}};
	assign parallel_out_first = store_q[FIRST_BIT];
	assign parallel_out_last  = store_q[W-1];
	assign cascade_serial_out = shift_q[W-1];

	// enable follows the clean pin level once it has stood for a cycle
	a_oe_follows: assert property (@(posedge clk) disable iff (!rst_n)
		!oe_s ##1 !oe_s |-> parallel_oe == '0)
		else $error("outputs driven while disabled");
	a_oe_drives: assert property (@(posedge clk) disable iff (!rst_n)
		oe_s ##1 oe_s |-> parallel_oe == '1)
		else $error("outputs not driven");
	// cascade is the last stage: it moves only on shift edges and is emptied by clear
	a_cascade_follows: assert property (@(posedge clk) disable iff (!rst_n)
		clr_n_s && sck_rise |=> cascade_serial_out == $past(shift_q[W-2]))
		else $error("cascade missed shift");
	a_cascade_holds: assert property (@(posedge clk) disable iff (!rst_n)
		clr_n_s && !sck_rise |=> $stable(cascade_serial_out))
		else $error("cascade moved without edge");
	a_cascade_tail: assert property (@(posedge clk) disable iff (!rst_n)
		!clr_n_s |=> !cascade_serial_out)
		else $error("cascade not cleared");
endmodule : srl_latch

// ===== verification/srl_host.sv
// host model: shifts a byte in msb first
`timescale 1ns/1ps
module srl_host
(
	// system
	input  wire logic       clk,
	input  wire logic       rstn,
	// command
	input  wire logic       go,
	input  wire logic [7:0] data,
	output logic            busy,
	// pins
	output logic            serial_in,
	output logic            shift_clock
);
	logic [5:0] cnt_q;
	////////////////////////////////
	// 80 ns bit slot; data set 40 ns ahead of the rise, held to the fall
	assign shift_clock = busy & cnt_q[2];
	// idle line shows the inverse, never a stale bit
	assign serial_in = busy ? data[3'd7 - cnt_q[5:3]] : ~data[0];
	// frame counter; clock stands low between frames
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy  <= 1'b0;
			cnt_q <= 6'h00;
		end
		else
		begin
			busy  <= go | (busy & ~&cnt_q);
			cnt_q <= busy ? cnt_q + 6'h01 : 6'h00;
		end
	end
endmodule : srl_host

// ===== verification/test_srl_latch.sv
// bench for the shift and storage latch
`timescale 1ns/1ps
module test_srl_latch;
	logic       clk, rstn, go, clr_n, stg_clk, oe_n;
	logic [7:0] data;
	wire        busy, si, sck, casc, pf, pl;
	wire  [7:0] pout, poe, pins;
	int         miscompares, n_checks;
	// resolved parallel pins
	assign pins = poe[0] ? pout : 8'hZZ;
	srl_latch srl_latch_i (.clk(clk), .rstn(rstn), .serial_in(si), .shift_clock(sck),
		.shift_clear_n(clr_n), .storage_clock(stg_clk), .output_enable_n(oe_n), .parallel_out(pout),
		.parallel_oe(poe), .parallel_out_first(pf), .parallel_out_last(pl), .cascade_serial_out(casc));
	srl_host srl_host_i (.clk(clk), .rstn(rstn), .go(go), .data(data), .busy(busy),
		.serial_in(si), .shift_clock(sck));
	////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// one frame; the pin sync needs about five cycles after it
	task automatic send(input logic [7:0] b);
		int i;
		data <= b;
		go   <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (busy !== 1'b0 && i < 200);
		if (i >= 200)
		begin
			miscompares++;
			conclude();
		end
		repeat (8) @(posedge clk);
	endtask : send
	task automatic store;
		stg_clk <= 1'b1;
		repeat (4) @(posedge clk);
		stg_clk <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : store
	////////////////////////////////
	task automatic t_load;
		send(8'hA5);
		store();
		oe_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pins, 8'hA5);
		chk({6'h00, pl, pf}, 8'h03);
		chk({7'h00, casc}, 8'h01);
	endtask : t_load
	task automatic t_hold;
		send(8'h3C);
		chk(pins, 8'hA5);
		chk({7'h00, casc}, 8'h00);
		store();
		chk(pins, 8'h3C);
	endtask : t_hold
	task automatic t_clear;
		clr_n <= 1'b0;
		send(8'hFF);
		chk({7'h00, casc}, 8'h00);
		clr_n <= 1'b1;
		store();
		chk(pins, 8'h00);
	endtask : t_clear
	task automatic t_float;
		oe_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(poe, 8'h00);
		chk(pins, 8'hZZ);
	endtask : t_float
	////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rstn, go, stg_clk, oe_n, clr_n, data} <= {5'b00011, 8'h00};
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (10) @(posedge clk);
		t_load();
		t_hold();
		t_clear();
		t_float();
		conclude();
	end
endmodule : test_srl_latch
